/* File: hdl/sws_sequencer.sv */
/*
 * sws_sequencer: parameter sweep sequencer with an APB register slave.
 * Assumes an APB master on pclk and a consumer of sweep_value that applies it to the selected source.
 */
// Notes on behaviour
// - index selects swept quantity zero to four
// - type zero linear, one logarithmic
// - end mode once, repeat, up/down
// - scan time clamped to 1728000 seconds
// - amplitude attenuator hold flag
// - dc level attenuator hold flag
// - fixed mode freezes relays during scan
// - interval index maps to dwell table
// - each step dwells the selected interval
// - enable loads begin value, no start
// - run starts or resumes, ignored running
// - pause suspends, ignored when paused
// - reset returns to begin, not started
// - read-only state code zero to four
// - separate begin and end values stored
// - frequency confined 1 mHz to 2.5 MHz
// - amplitude confined 1 nV to 2 V
// - dc within 5 V, aux 10.5 V
`timescale 1ns/1ps
module sws_sequencer
    import sws_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] sweep_value,
    output logic [2:0] sweep_quantity,
    output logic sweep_update,
    output logic amp_atten_freeze,
    output logic dc_atten_freeze,
    output logic [2:0] sweep_state_code
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    sws_ctrl_t ctrl_reg;
    sws_state_t state_reg;
    logic [20:0] duration_reg;
    logic [31:0] ratio_up_reg, ratio_dn_reg, value_reg, inc_reg, nsteps_reg, step_reg, prdata_reg;
    logic [31:0] lim_reg [0:9];
    logic dir_reg, wrap_reg, upd_reg, amp_frz_reg, dc_frz_reg;
    logic [2:0] code_reg;
    logic [15:0] tick_reg;
    logic [21:0] ms_reg;
    logic [47:0] quo_reg;
    logic [31:0] rem_reg, den_reg;
    logic [5:0] dcnt_reg;
    logic phase_reg;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [5:0] word, lim_sel;
    logic is_lim, mapped, wr, ctrl_wr, cmd_wr, run_req, pause_req, rst_req, en_rise, en_fall;
    sws_ctrl_t ctrl_new;
    assign word = paddr[7:2];
    assign lim_sel = word - OFF_LIM[7:2];
    assign is_lim = (word >= OFF_LIM[7:2]) && (lim_sel < LIM_COUNT);
    assign mapped = (paddr[1:0] == 2'h0) && (is_lim || paddr == OFF_CTRL || paddr == OFF_CMD
        || paddr == OFF_STAT || paddr == OFF_VALUE || paddr == OFF_DUR || paddr == OFF_RUP || paddr == OFF_RDN);
    assign wr = psel && penable && pwrite && mapped;
    assign ctrl_wr = wr && paddr == OFF_CTRL;
    assign cmd_wr = wr && paddr == OFF_CMD;
    assign run_req = cmd_wr && pwdata[CMD_RUN];
    assign pause_req = cmd_wr && pwdata[CMD_PAUSE];
    assign rst_req = cmd_wr && pwdata[CMD_RESET];
    assign ctrl_new = sws_ctrl_t'(pwdata[$bits(sws_ctrl_t)-1:0]);
    assign en_rise = ctrl_wr && ctrl_new.enable && !ctrl_reg.enable;
    assign en_fall = ctrl_wr && !ctrl_new.enable;
    // zero wait states: the read word is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    // clamp a written begin/end value to the range of its quantity
    function automatic logic [31:0] clamp_val(input logic [2:0] q, input logic [31:0] v);
        logic signed [31:0] s;
        logic signed [31:0] lim;
        s = $signed(v);
        lim = (q == Q_DC) ? DC_LIM : AUX_LIM;
        case (q)
            Q_FREQ: clamp_val = (v < FREQ_MIN) ? FREQ_MIN : (v > FREQ_MAX) ? FREQ_MAX : v;
            Q_AMP: clamp_val = (v < AMP_MIN) ? AMP_MIN : (v > AMP_MAX) ? AMP_MAX : v;
            default: clamp_val = (s > lim) ? lim : (s < -lim) ? -lim : v;
        endcase
    endfunction

    // control, duration and ratio registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
            duration_reg <= DUR_RST;
            ratio_up_reg <= RATIO_RST;
            ratio_dn_reg <= RATIO_RST;
        end else if (wr) begin
            if (paddr == OFF_CTRL) begin
                ctrl_reg <= ctrl_new;
                // out-of-range indices are pinned to the last legal entry
                if (ctrl_new.qsel > Q_AUX2) ctrl_reg.qsel <= Q_AUX2;
                if (ctrl_new.dwell > DWELL_MAX_IDX) ctrl_reg.dwell <= DWELL_MAX_IDX;
                if (ctrl_new.end_mode > E_UPDOWN) ctrl_reg.end_mode <= E_UPDOWN;
            end
            if (paddr == OFF_DUR) begin
                duration_reg <= (pwdata > 32'(DUR_MAX_S)) ? DUR_MAX_S : pwdata[20:0];
            end
            if (paddr == OFF_RUP) ratio_up_reg <= pwdata;
            if (paddr == OFF_RDN) ratio_dn_reg <= pwdata;
        end
    end

    // begin/end pairs, two words per quantity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 10; i++) lim_reg[i] <= LIM_RST;
        end else if (wr && is_lim) begin
            lim_reg[lim_sel[3:0]] <= clamp_val(lim_sel[3:1], pwdata);
        end
    end

    // ------------------------------------------------------------------
    // sweep datapath
    // ------------------------------------------------------------------
    logic [31:0] beg_val, end_val, mag, dur_ms, next_val, endpoint;
    logic [63:0] prod;
    logic [21:0] dwell_ms;
    logic [32:0] trial;
    logic [47:0] quo_next;
    logic signed_q, going_up, add, dwell_done, last, calc_done;
    assign beg_val = lim_reg[{ctrl_reg.qsel, 1'b0}];
    assign end_val = lim_reg[{ctrl_reg.qsel, 1'b1}];
    assign signed_q = ctrl_reg.qsel >= Q_DC;
    assign going_up = signed_q ? ($signed(end_val) >= $signed(beg_val)) : (end_val >= beg_val);
    assign mag = going_up ? end_val - beg_val : beg_val - end_val;
    assign dur_ms = 32'(duration_reg) * MS_PER_S;
    assign dwell_ms = DWELL_MS[ctrl_reg.dwell];
    // the outward pass moves toward end, the return pass toward begin
    assign add = (going_up == !dir_reg);
    assign prod = value_reg * (dir_reg ? ratio_dn_reg : ratio_up_reg);
    // linear adds or subtracts a fixed increment, log multiplies by a q8.24 ratio
    assign next_val = (ctrl_reg.log_type == T_LOG) ? prod[55:24]
        : add ? value_reg + inc_reg : value_reg - inc_reg;
    assign endpoint = dir_reg ? beg_val : end_val;
    assign last = (step_reg + 32'h1) >= nsteps_reg;
    assign dwell_done = (state_reg == ST_RUN) && (tick_reg == 16'(MS_CYCLES - 1)) && (ms_reg == dwell_ms - 22'h1);
    assign trial = {rem_reg, quo_reg[47]};
    assign quo_next = {quo_reg[46:0], trial >= {1'b0, den_reg}};
    assign calc_done = (state_reg == ST_CALC) && phase_reg && (dcnt_reg == 6'h0);

    // serial divider: steps = scan ms / dwell ms, then increment = span / steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quo_reg <= '0;
            rem_reg <= '0;
            den_reg <= 32'h1;
            dcnt_reg <= DIV_LAST;
            phase_reg <= 1'b0;
            nsteps_reg <= 32'h1;
            inc_reg <= '0;
        end else if (state_reg != ST_CALC) begin
            quo_reg <= {16'h0, dur_ms};
            rem_reg <= '0;
            den_reg <= 32'(dwell_ms);
            dcnt_reg <= DIV_LAST;
            phase_reg <= 1'b0;
        end else begin
            quo_reg <= quo_next;
            rem_reg <= (trial >= {1'b0, den_reg}) ? 32'(trial - {1'b0, den_reg}) : trial[31:0];
            dcnt_reg <= dcnt_reg - 6'h1;
            if (dcnt_reg == 6'h0 && !phase_reg) begin
                // a scan shorter than one dwell still takes one step
                nsteps_reg <= (quo_next[31:0] == 32'h0) ? 32'h1 : quo_next[31:0];
                den_reg <= (quo_next[31:0] == 32'h0) ? 32'h1 : quo_next[31:0];
                quo_reg <= {16'h0, mag};
                rem_reg <= '0;
                dcnt_reg <= DIV_LAST;
                phase_reg <= 1'b1;
            end
            if (calc_done) inc_reg <= quo_next[31:0];
        end
    end

    // dwell timer: millisecond ticks, held while paused
    // a pause on the last cycle of a dwell freezes the timer at its end, so the step is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= '0;
            ms_reg <= '0;
        end else if (state_reg == ST_RUN && !pause_req) begin
            tick_reg <= (tick_reg == 16'(MS_CYCLES - 1)) ? 16'h0 : tick_reg + 16'h1;
            if (dwell_done) ms_reg <= '0;
            else if (tick_reg == 16'(MS_CYCLES - 1)) ms_reg <= ms_reg + 22'h1;
        end else if (state_reg != ST_PAUSE && state_reg != ST_RUN) begin
            tick_reg <= '0;
            ms_reg <= '0;
        end
    end

    // ------------------------------------------------------------------
    // sequencing state machine
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_OFF;
            value_reg <= LIM_RST;
            dir_reg <= 1'b0;
            wrap_reg <= 1'b0;
            step_reg <= '0;
            upd_reg <= 1'b0;
        end else begin
            upd_reg <= 1'b0;
            if (en_fall) begin
                state_reg <= ST_OFF;
            end else if (en_rise || (rst_req && state_reg != ST_OFF)) begin
                state_reg <= ST_READY;
                value_reg <= beg_val;
                dir_reg <= 1'b0;
                wrap_reg <= 1'b0;
                step_reg <= '0;
                upd_reg <= 1'b1;
            end else begin
                case (state_reg)
                    ST_READY: begin
                        // follow begin edits until the scan starts
                        value_reg <= beg_val;
                        if (run_req) state_reg <= ST_CALC;
                    end
                    ST_CALC: begin
                        if (calc_done) state_reg <= ST_RUN;
                    end
                    ST_RUN: begin
                        if (pause_req) begin
                            state_reg <= ST_PAUSE;
                        end else if (dwell_done) begin
                            upd_reg <= 1'b1;
                            if (wrap_reg) begin
                                value_reg <= beg_val;
                                wrap_reg <= 1'b0;
                                step_reg <= '0;
                            end else if (last) begin
                                // exact endpoint hides increment truncation
                                value_reg <= endpoint;
                                step_reg <= '0;
                                case (ctrl_reg.end_mode)
                                    E_ONCE: state_reg <= ST_DONE;
                                    E_REPEAT: wrap_reg <= 1'b1;
                                    default: dir_reg <= !dir_reg;
                                endcase
                            end else begin
                                value_reg <= next_val;
                                step_reg <= step_reg + 32'h1;
                            end
                        end
                    end
                    ST_PAUSE: begin
                        if (run_req) state_reg <= ST_RUN;
                    end
                    ST_DONE: begin
                        if (run_req) begin
                            state_reg <= ST_CALC;
                            value_reg <= beg_val;
                            dir_reg <= 1'b0;
                            upd_reg <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // registered outputs: state code and attenuator freezes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_reg <= CODE_OFF;
            amp_frz_reg <= 1'b0;
            dc_frz_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_READY: code_reg <= CODE_RESET;
                ST_CALC, ST_RUN: code_reg <= CODE_RUN;
                ST_PAUSE: code_reg <= CODE_PAUSE;
                ST_DONE: code_reg <= CODE_DONE;
                default: code_reg <= CODE_OFF;
            endcase
            amp_frz_reg <= ctrl_reg.amp_hold && ctrl_reg.qsel == Q_AMP
                && (state_reg inside {ST_CALC, ST_RUN, ST_PAUSE});
            dc_frz_reg <= ctrl_reg.dc_hold && ctrl_reg.qsel == Q_DC
                && (state_reg inside {ST_CALC, ST_RUN, ST_PAUSE});
        end
    end

    // read word captured at setup; command and unmapped read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (psel && !penable) begin
            prdata_reg <= '0;
            if (is_lim && paddr[1:0] == 2'h0) prdata_reg <= lim_reg[lim_sel[3:0]];
            case (paddr)
                OFF_CTRL: prdata_reg <= 32'(ctrl_reg);
                OFF_STAT: prdata_reg <= {26'h0, wrap_reg, dir_reg, 1'b0, code_reg};
                OFF_VALUE: prdata_reg <= value_reg;
                OFF_DUR: prdata_reg <= 32'(duration_reg);
                OFF_RUP: prdata_reg <= ratio_up_reg;
                OFF_RDN: prdata_reg <= ratio_dn_reg;
                default: ;
            endcase
        end
    end

    assign sweep_value = value_reg;
    assign sweep_quantity = ctrl_reg.qsel;
    assign sweep_update = upd_reg;
    assign amp_atten_freeze = amp_frz_reg;
    assign dc_atten_freeze = dc_frz_reg;
    assign sweep_state_code = code_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic quiet;
    assign quiet = !ctrl_wr && !cmd_wr;

    property p_code_run;
        state_reg == ST_RUN |=> sweep_state_code == CODE_RUN;
    endproperty
    a_code_run: assert property (p_code_run) else $error("running state not reported as 2");
    property p_dur_max;
        duration_reg <= DUR_MAX_S;
    endproperty
    a_dur_max: assert property (p_dur_max) else $error("scan time above limit");
    property p_enable;
        en_rise |=> state_reg == ST_READY && value_reg == $past(beg_val) ##1 state_reg == ST_READY || !quiet;
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not load begin without start");
    property p_run_ignored;
        state_reg == ST_RUN && run_req && !pause_req && !rst_req |=> state_reg == ST_RUN;
    endproperty
    a_run_ignored: assert property (p_run_ignored) else $error("run disturbed a running scan");
    property p_pause;
        state_reg == ST_RUN && pause_req && !rst_req && !ctrl_wr |=> state_reg == ST_PAUSE;
    endproperty
    a_pause: assert property (p_pause) else $error("pause not taken");
    property p_pause_hold;
        state_reg == ST_PAUSE && quiet [*2] |-> $stable(value_reg) && $stable(ms_reg);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("value moved while paused");
    property p_reset;
        rst_req && !ctrl_wr && state_reg != ST_OFF |=> state_reg == ST_READY && value_reg == $past(beg_val);
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not return to begin");
    property p_freeze;
        state_reg == ST_RUN && ctrl_reg.qsel == Q_AMP && ctrl_reg.amp_hold && !ctrl_wr |=> amp_atten_freeze;
    endproperty
    a_freeze: assert property (p_freeze) else $error("amplitude attenuators not frozen");
    property p_once_done;
        dwell_done && last && !wrap_reg && ctrl_reg.end_mode == E_ONCE && quiet
            |=> state_reg == ST_DONE ##1 sweep_state_code == CODE_DONE;
    endproperty
    a_once_done: assert property (p_once_done) else $error("single pass did not finish");
    property p_lin_step;
        dwell_done && !last && !wrap_reg && ctrl_reg.log_type != T_LOG && add && quiet
            |=> value_reg == $past(value_reg) + $past(inc_reg);
    endproperty
    a_lin_step: assert property (p_lin_step) else $error("linear step wrong");
    property p_freq_range;
        lim_reg[0] >= FREQ_MIN && lim_reg[0] <= FREQ_MAX;
    endproperty
    a_freq_range: assert property (p_freq_range) else $error("begin frequency out of range");

    c_pause_resume: cover property (state_reg == ST_PAUSE ##1 state_reg == ST_RUN);
    c_done: cover property (state_reg == ST_RUN ##1 state_reg == ST_DONE);
    c_reverse: cover property (dwell_done && last && ctrl_reg.end_mode == E_UPDOWN);
    c_repeat: cover property (wrap_reg && dwell_done);
endmodule

/* File: inc/sws_pkg.sv */
/*
 * sws_pkg: register map, field layout, limits, dwell table and states of the sweep sequencer.
 * Assumes a 40 MHz pclk and a 32-bit APB master with byte addresses.
 */
package sws_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_VALUE = 8'h0c;
    localparam logic [7:0] OFF_DUR = 8'h10;
    localparam logic [7:0] OFF_RUP = 8'h14;
    localparam logic [7:0] OFF_RDN = 8'h18;
    localparam logic [7:0] OFF_LIM = 8'h20;
    localparam logic [5:0] LIM_COUNT = 6'h0a;
    // command register bit positions
    localparam int CMD_RUN = 0;
    localparam int CMD_PAUSE = 1;
    localparam int CMD_RESET = 2;
    // quantity, type and end-mode codes
    localparam logic [2:0] Q_FREQ = 3'h0;
    localparam logic [2:0] Q_AMP = 3'h1;
    localparam logic [2:0] Q_DC = 3'h2;
    localparam logic [2:0] Q_AUX2 = 3'h4;
    localparam logic T_LOG = 1'h1;
    localparam logic [1:0] E_ONCE = 2'h0;
    localparam logic [1:0] E_REPEAT = 2'h1;
    localparam logic [1:0] E_UPDOWN = 2'h2;
    // state codes seen by software
    localparam logic [2:0] CODE_OFF = 3'h0;
    localparam logic [2:0] CODE_RESET = 3'h1;
    localparam logic [2:0] CODE_RUN = 3'h2;
    localparam logic [2:0] CODE_PAUSE = 3'h3;
    localparam logic [2:0] CODE_DONE = 3'h4;
    // ------------------------------------------------------------------
    // limits: freq in mHz, amplitude in nV, dc in 0.1 mV, aux in mV
    // ------------------------------------------------------------------
    localparam logic [20:0] DUR_MAX_S = 21'h1a5e00;
    localparam logic [31:0] MS_PER_S = 32'h3e8;
    localparam logic [31:0] FREQ_MIN = 32'h1;
    localparam logic [31:0] FREQ_MAX = 32'h9502f900;
    localparam logic [31:0] AMP_MIN = 32'h1;
    localparam logic [31:0] AMP_MAX = 32'h77359400;
    localparam logic signed [31:0] DC_LIM = 32'sh0000c350;
    localparam logic signed [31:0] AUX_LIM = 32'sh00002904;
    localparam logic [4:0] DWELL_MAX_IDX = 5'h10;
    localparam logic [21:0] DWELL_MS [0:16] = '{22'h8, 22'h10, 22'h1f, 22'h4e, 22'h9b, 22'h1d5, 22'h3aa,
        22'h753, 22'h1250, 22'h249f, 22'h6dd8, 22'hdbba, 22'h1b774, 22'h52468, 22'ha4cb8, 22'h149970, 22'h2932e0};
    // timing: one millisecond tick derived from the clock period
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] DIV_LAST = 6'h2f;
    // reset values
    localparam logic [20:0] DUR_RST = 21'h0;
    localparam logic [31:0] RATIO_RST = 32'h01000000;
    localparam logic [31:0] LIM_RST = 32'h1;

    typedef struct packed {
        logic enable;
        logic [4:0] dwell;
        logic dc_hold;
        logic amp_hold;
        logic [1:0] end_mode;
        logic log_type;
        logic [2:0] qsel;
    } sws_ctrl_t;

    typedef enum logic [2:0] {ST_OFF, ST_READY, ST_CALC, ST_RUN, ST_PAUSE, ST_DONE} sws_state_t;
endpackage

/* File: test/sws_source_model.sv */
/*
 * sws_source_model: stand-in for the source that applies each swept value.
 * Assumes sweep_update is a one-cycle pulse in the pclk domain.
 */
`timescale 1ns/1ps
module sws_source_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sweep_update,
    input wire logic [31:0] sweep_value,
    input wire logic [2:0] sweep_quantity,
    output logic applied,
    output logic [31:0] applied_value,
    output logic [2:0] applied_qty,
    output logic [15:0] gap
);
    logic [15:0] cnt_reg;
    // apply on the pulse and note how long the old value stood
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied <= 1'b0;
            applied_value <= 32'h0;
            applied_qty <= 3'h0;
            gap <= 16'h0;
            cnt_reg <= 16'h0;
        end else begin
            applied <= sweep_update;
            cnt_reg <= sweep_update ? 16'h0 : cnt_reg + 16'h1;
            if (sweep_update) begin
                applied_value <= sweep_value;
                applied_qty <= sweep_quantity;
                gap <= cnt_reg + 16'h1; // edges since the last update
            end
        end
    end
endmodule

/* File: test/sws_sequencer_tb_top.sv */
/*
 * sws_sequencer_tb_top: self-checking bench, APB master plus source model.
 * Assumes sws_pkg and a small MS_CYCLES so one dwell is 32 cycles.
 */
`timescale 1ns/1ps
module sws_sequencer_tb_top
    import sws_pkg::*;
;
    localparam int MSC = 4;
    logic pclk = 0, presetn, psel, penable, pwrite, applied, chk_dwell = 0;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, sweep_value, src_value, rv;
    logic pready, pslverr, sweep_update, amp_atten_freeze, dc_atten_freeze;
    logic [2:0] sweep_quantity, sweep_state_code, src_qty;
    logic [15:0] gap;
    logic [32:0] ae, ev;
    logic [32:0] apq[$];
    logic [32:0] vq[$]; // freeze expected, value
    int n_mismatch = 0, compares = 0, cyc = 0, seed = 22;

    always #12.5 pclk = ~pclk;

    sws_sequencer #(.MS_CYCLES(MSC)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sweep_value, .sweep_quantity, .sweep_update, .amp_atten_freeze,
        .dc_atten_freeze, .sweep_state_code);
    sws_source_model src (.pclk, .presetn, .sweep_update, .sweep_value, .sweep_quantity, .applied,
        .applied_value(src_value), .applied_qty(src_qty), .gap);

    task automatic give_verdict();
        if (n_mismatch == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // one apb transfer; the expected answer is queued for the monitor
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er,
        input logic [31:0] x);
        apq.push_back({er, x});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0, 1'b0, x);
    endtask

    // code lags the state by a cycle, so give it three edges to settle
    task automatic chk_state(input logic [2:0] x);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp("state", {29'h0, x}, {29'h0, sweep_state_code});
    endtask

    // apb monitor and the hang limit
    always @(posedge pclk) begin
        cyc++;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            ae = apq.pop_front();
            cmp("pslverr", {31'h0, ae[32]}, {31'h0, pslverr});
            if (pwrite === 1'b0) cmp("prdata", ae[31:0], prdata);
        end
        if (cyc == 30000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // each applied value is taken against the oldest expected step
    // the freeze is seen two edges after the step, so leaving the scan shows it low
    always @(posedge pclk) begin
        if (applied === 1'b1 && vq.size() == 0) cmp("update", 32'h0, 32'h1);
        else if (applied === 1'b1) begin
            ev = vq.pop_front();
            cmp("value", ev[31:0], src_value);
            cmp("quantity", {29'h0, Q_DC}, {29'h0, src_qty});
            cmp("amp_freeze", 32'h0, {31'h0, amp_atten_freeze});
            cmp("dc_freeze", {31'h0, ev[32]}, {31'h0, dc_atten_freeze});
            if (chk_dwell) cmp("dwell", DWELL_MS[0] * MSC, {16'h0, gap});
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_STAT, 32'h0);
        rd(OFF_RUP, RATIO_RST);
        rd(OFF_LIM, LIM_RST);
        xfer(1'b0, 8'h1c, 32'h0, 1'b1, 32'h0);
        xfer(1'b1, 8'h02, 32'h0, 1'b1, 32'h0);
        wr(OFF_STAT, 32'h7);
        rd(OFF_STAT, 32'h0);
        wr(OFF_CTRL, 32'h1fff);
        rd(OFF_CTRL, 32'h10ec);
        wr(OFF_DUR, 32'hffffffff);
        rd(OFF_DUR, {11'h0, DUR_MAX_S});
        rv = $random(seed);
        wr(8'h24, {1'b0, rv[30:0]} | 32'h1);
        rd(8'h24, {1'b0, rv[30:0]} | 32'h1);
        wr(8'h24, 32'hffffffff);
        rd(8'h24, FREQ_MAX);
        wr(8'h20, 32'h0);
        rd(8'h20, FREQ_MIN);
        wr(8'h2c, 32'hffffffff);
        rd(8'h2c, AMP_MAX);
        wr(8'h30, -32'sd100000);
        rd(8'h30, -DC_LIM);
        wr(8'h3c, 32'd20000);
        rd(8'h3c, AUX_LIM);
        // dc level, linear, once, 1 s at 8 ms: 125 steps of 2, set up before enable and run
        wr(8'h30, 32'h0);
        wr(8'h34, 32'd250);
        wr(OFF_DUR, 32'h1);
        wr(OFF_CTRL, 32'h0082);
        vq.push_back(33'h0);
        wr(OFF_CTRL, 32'h2082);
        chk_state(CODE_RESET);
        for (int v = 2; v <= 250; v += 2) vq.push_back({v < 250, 32'(v)});
        wr(OFF_CMD, 32'h1);
        chk_state(CODE_RUN);
        while (vq.size() > 120) @(posedge pclk);
        chk_dwell = 1'b1;
        repeat (200) @(posedge pclk);
        chk_dwell = 1'b0;
        wr(OFF_CMD, 32'h2);
        chk_state(CODE_PAUSE);
        wr(OFF_CMD, 32'h2);
        chk_state(CODE_PAUSE);
        wr(OFF_CMD, 32'h1);
        wr(OFF_CMD, 32'h1);
        chk_state(CODE_RUN);
        repeat (100) @(posedge pclk);
        wr(OFF_CMD, 32'h2);
        chk_state(CODE_PAUSE);
        vq.delete();
        vq.push_back(33'h0);
        wr(OFF_CMD, 32'h4);
        chk_state(CODE_RESET);
        for (int v = 2; v <= 250; v += 2) vq.push_back({v < 250, 32'(v)});
        wr(OFF_CMD, 32'h1);
        while (vq.size() > 0) @(posedge pclk);
        repeat (40) @(posedge pclk);
        chk_state(CODE_DONE);
        rd(OFF_VALUE, 32'd250);
        // up/down from done: restart at begin, up to end, back down to begin, then switch off
        wr(OFF_CTRL, 32'h20a2);
        vq.push_back({1'b1, 32'h0});
        for (int v = 2; v <= 250; v += 2) vq.push_back({1'b1, 32'(v)});
        for (int v = 248; v >= 0; v -= 2) vq.push_back({1'b1, 32'(v)});
        wr(OFF_CMD, 32'h1);
        chk_state(CODE_RUN);
        while (vq.size() > 0) @(posedge pclk);
        wr(OFF_CTRL, 32'h00a2);
        chk_state(CODE_OFF);
        rd(OFF_VALUE, 32'h0);
        give_verdict();
    end
endmodule
